// *** logic/tlic_pkg.sv ***
// Package for the two-level interrupt priority controller.
// Assumes an 8-bit special function register port driven by the CPU core.
package tlic_pkg;

  // Register addresses on the special function register port.
  localparam logic [7:0] ADDR_ENABLE_MAIN = 8'ha8;
  localparam logic [7:0] ADDR_LEVEL_MAIN  = 8'hb8;
  localparam logic [7:0] ADDR_ENABLE_EXT1 = 8'he6;

  // Reset values of the three registers.
  localparam logic [7:0] RST_ENABLE_MAIN = 8'h00;
  localparam logic [7:0] RST_LEVEL_MAIN  = 8'h00;
  localparam logic [7:0] RST_ENABLE_EXT1 = 8'h00;

  // Field positions in the main enable register.
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int SPARE_SW_FLAG_BIT     = 6;

  // Number of sources that this block masks and the width of their rank field.
  localparam int MAIN_SOURCES   = 6;
  localparam int EXT_SOURCES    = 8;
  localparam int NUM_SOURCES    = 22;
  localparam int RANK_W         = 5;

  // Unused level bits read back as ones.
  localparam logic [1:0] LEVEL_UNUSED_READ = 2'h3;

  // Vector of rank 0 and the stride between ranks.
  localparam logic [15:0] VECTOR_BASE   = 16'h0003;
  localparam logic [15:0] VECTOR_STRIDE = 16'h0008;

  // Cycle figures of the response: detect, long call, return, and an eight-clock divide.
  localparam int DETECT_CLOCKS   = 1;
  localparam int LCALL_CLOCKS    = 4;
  localparam int MIN_RESPONSE    = DETECT_CLOCKS + LCALL_CLOCKS;
  localparam int RETI_CLOCKS     = 5;
  localparam int DIV_CLOCKS      = 8;
  localparam int MAX_RESPONSE    = DETECT_CLOCKS + RETI_CLOCKS + DIV_CLOCKS + LCALL_CLOCKS;

endpackage : tlic_pkg

// *** logic/tlic_arbiter.sv ***
// Fixed-rank two-level arbiter for the interrupt controller.
// Assumes requests are already masked; purely combinational.
`timescale 1ns/100ps

module tlic_arbiter #(
  parameter int N      = 22,
  parameter int RANK_W = 5
) (
  input  wire logic [N-1:0]      i_req,
  input  wire logic [N-1:0]      i_high,
  output logic                   o_valid,
  output logic                   o_level,
  output logic [RANK_W-1:0]      o_rank
);

  initial begin
    if (N > (1 << RANK_W)) begin
      $error("Rank field too narrow for the number of sources.");
    end
  end

  wire logic [N-1:0] req_high = i_req & i_high;
  wire logic [N-1:0] req_low  = i_req & ~i_high;
  wire logic         any_high = |req_high;
  // A high request shades every low request regardless of rank.
  wire logic [N-1:0] pool     = any_high ? req_high : req_low;

  // Lowest index wins; scanning from the top down leaves rank 0 last to assign.
  always_comb begin
    o_rank = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (pool[k]) begin
        o_rank = RANK_W'(k);
      end
    end
  end

  assign o_valid = |i_req;
  assign o_level = any_high;

endmodule : tlic_arbiter

// *** logic/tlic_ctrl.sv ***
// Two-level interrupt priority controller: enable, level and arbitration logic.
// Assumes the CPU core owns the register port, the pending flags come from peripherals
// on the same clock, and the core reports routine entry and return-from-interrupt.
`timescale 1ns/100ps

// How it works
// - Every source has its own level bit choosing low or high service.
// - An enabled high request may preempt a running low-level routine.
// - Nothing preempts a running high-level routine.
// - Every level bit resets to low.
// - Among simultaneous requests a high one wins over any low one.
// - Ties within one level are broken by a fixed unchanging rank.
// - Rank follows the source list, vector 0x0003 for rank 0 to 0x00ab.
// - Pending flags are sampled and resolved on every clock.
// - Fastest response is one detect clock plus the four-clock long call.
// - After a return one more instruction runs before a pending call.
// - Worst response is 18 clocks: detect, return, divide, long call.
// - Equal or lower requests wait for return plus one instruction.
// - Global enable bit 7 blocks everything when zero.
// - Main enable bit 6 is plain storage with no effect.
// - Main enable bits 5..0 mask timer2, serial0, timer1, pin1, timer0, pin0.
// - Main level bits 5..0 set level of those six sources.
// - Main level bits 7..6 read as ones and ignore writes.
// - Extended enable bits 7..0 mask comparators, counter array, window, two-wire, SPI.
// - A flag still set after return raises a fresh request once the hold-off ends.
// - A flag set by software requests exactly like a hardware event.
module tlic_ctrl #(
  parameter int NUM_SOURCES = tlic_pkg::NUM_SOURCES
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_sys_rst,
  // Special function register port from the core.
  input  wire logic [7:0]             i_sfr_addr,
  input  wire logic                   i_sfr_wr,
  input  wire logic [7:0]             i_sfr_wdata,
  output logic      [7:0]             o_sfr_rdata,
  output logic                        o_sfr_hit,
  // Pending flags by rank, and enables and levels of ranks held elsewhere.
  input  wire logic [NUM_SOURCES-1:0] i_pending,
  input  wire logic [NUM_SOURCES-1:0] i_ext_enable,
  input  wire logic [NUM_SOURCES-1:0] i_ext_level,
  // Core sequencing reports.
  input  wire logic                   i_instr_done,
  input  wire logic                   i_enter,
  input  wire logic                   i_reti_done,
  // Request to the core.
  output logic                        o_irq_req,
  output logic      [15:0]            o_irq_vector,
  output logic                        o_irq_level,
  output logic      [4:0]             o_irq_rank,
  // State for observation.
  output logic                        o_active_low,
  output logic                        o_active_high,
  output logic                        o_spare_sw_flag
);

  initial begin
    if (NUM_SOURCES < tlic_pkg::MAIN_SOURCES + tlic_pkg::EXT_SOURCES
        || NUM_SOURCES > 32) begin
      $error("Source count outside the range this controller serves.");
    end
  end

  // Hold-off after a return: a pending call waits one completed instruction.
  typedef enum logic [1:0] {TLIC_RUN, TLIC_AFTER_RETI} tlic_state_t;

  logic [7:0]  enable_main_reg;
  logic [5:0]  level_main_reg;
  logic [7:0]  enable_ext1_reg;
  logic        active_low_reg;
  logic        active_high_reg;
  logic        active_low_next;
  logic        active_high_next;
  tlic_state_t state_reg;
  tlic_state_t state_next;
  logic        req_reg;
  logic        level_reg;
  logic [4:0]  rank_reg;
  logic [15:0] vector_reg;

  // Address decode of the three registers.
  wire logic hit_en_main = (i_sfr_addr == tlic_pkg::ADDR_ENABLE_MAIN);
  wire logic hit_lv_main = (i_sfr_addr == tlic_pkg::ADDR_LEVEL_MAIN);
  wire logic hit_en_ext1 = (i_sfr_addr == tlic_pkg::ADDR_ENABLE_EXT1);
  wire logic wr_en_main  = i_sfr_wr & hit_en_main;
  wire logic wr_lv_main  = i_sfr_wr & hit_lv_main;
  wire logic wr_en_ext1  = i_sfr_wr & hit_en_ext1;

  // Register storage; the level bits come out of reset at low.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      enable_main_reg <= tlic_pkg::RST_ENABLE_MAIN;
      level_main_reg  <= tlic_pkg::RST_LEVEL_MAIN[5:0];
      enable_ext1_reg <= tlic_pkg::RST_ENABLE_EXT1;
    end else begin
      if (wr_en_main) begin
        enable_main_reg <= i_sfr_wdata; // Bit 6 is kept and drives only o_spare_sw_flag.
      end
      if (wr_lv_main) begin
        level_main_reg <= i_sfr_wdata[5:0]; // Upper two bits are dropped.
      end
      if (wr_en_ext1) begin
        enable_ext1_reg <= i_sfr_wdata;
      end
    end
  end

  // Read mux; an unmapped address reads zero and drops the hit flag.
  assign o_sfr_hit   = hit_en_main | hit_lv_main | hit_en_ext1;
  assign o_sfr_rdata = hit_en_main ? enable_main_reg :
                       hit_lv_main ? {tlic_pkg::LEVEL_UNUSED_READ, level_main_reg} :
                       hit_en_ext1 ? enable_ext1_reg : 8'h00;

  assign o_spare_sw_flag = enable_main_reg[tlic_pkg::SPARE_SW_FLAG_BIT];

  // Per-rank enable and level. Ranks 0..5 sit in main bits 0..5 in order, and ranks
  // 6..13 have enables in extended bits 0..7; their levels and the rest come from the ports.
  logic [NUM_SOURCES-1:0] src_enable;
  logic [NUM_SOURCES-1:0] src_high;
  genvar g;
  generate
    for (g = 0; g < NUM_SOURCES; g++) begin : g_src
      if (g < tlic_pkg::MAIN_SOURCES) begin : g_main
        assign src_enable[g] = enable_main_reg[g];
        assign src_high[g]   = level_main_reg[g]; // One level bit per source.
      end else if (g < tlic_pkg::MAIN_SOURCES + tlic_pkg::EXT_SOURCES) begin : g_ext
        assign src_enable[g] = enable_ext1_reg[g - tlic_pkg::MAIN_SOURCES];
        assign src_high[g]   = i_ext_level[g];
      end else begin : g_rest
        assign src_enable[g] = i_ext_enable[g];
        assign src_high[g]   = i_ext_level[g];
      end
    end
  endgenerate

  // Masking. Pending flags are used as is, so a flag set by software or one left set
  // after a return counts exactly like a new hardware event.
  wire logic                   global_en = enable_main_reg[tlic_pkg::GLOBAL_IRQ_ENABLE_BIT];
  wire logic [NUM_SOURCES-1:0] masked    = i_pending & src_enable & {NUM_SOURCES{global_en}};

  // Only a level above the one in service may preempt: high beats low, and a high
  // routine blocks all; equal or lower waits for its return.
  wire logic [NUM_SOURCES-1:0] eligible  = active_high_reg ? '0 :
                                           active_low_reg  ? (masked & src_high) : masked;

  logic        win_valid;
  logic        win_level;
  logic [4:0]  win_rank;

  tlic_arbiter #(
    .N      (NUM_SOURCES),
    .RANK_W (tlic_pkg::RANK_W)
  ) u_arbiter (
    .i_req   (eligible),
    .i_high  (src_high),
    .o_valid (win_valid),
    .o_level (win_level),
    .o_rank  (win_rank)
  );

  // Vector of the winner: base plus eight per rank.
  wire logic [15:0] win_vector = tlic_pkg::VECTOR_BASE
                                 + 16'({11'h000, win_rank} << 3);

  // Active-level tracking. Entry marks the level taken; a return clears the highest
  // active one, which is the routine in service.
  always_comb begin
    active_low_next  = active_low_reg;
    active_high_next = active_high_reg;
    if (i_reti_done) begin
      if (active_high_reg) begin
        active_high_next = 1'b0;
      end else begin
        active_low_next = 1'b0;
      end
    end
    if (i_enter) begin
      if (level_reg) begin
        active_high_next = 1'b1;
      end else begin
        active_low_next = 1'b1;
      end
    end
  end

  // After a return, hold the request until one further instruction completes.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TLIC_RUN: begin
        if (i_reti_done) begin
          state_next = TLIC_AFTER_RETI;
        end
      end
      TLIC_AFTER_RETI: begin
        if (i_instr_done) begin
          state_next = TLIC_RUN;
        end
      end
      default: begin
        state_next = TLIC_RUN;
      end
    endcase
  end

  // The instruction that completes the hold-off lets the request out on the very next
  // edge, so the return-plus-divide path costs no extra clock.
  wire logic hold_off = ((state_reg == TLIC_AFTER_RETI) & ~i_instr_done) | i_reti_done;

  // Request register: the winner is resolved every clock and shown one clock later,
  // which is the single detect clock ahead of the four-clock long call.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg       <= TLIC_RUN;
      active_low_reg  <= 1'b0;
      active_high_reg <= 1'b0;
      req_reg         <= 1'b0;
      level_reg       <= 1'b0;
      rank_reg        <= 5'h00;
      vector_reg      <= 16'h0000;
    end else begin
      state_reg       <= state_next;
      active_low_reg  <= active_low_next;
      active_high_reg <= active_high_next;
      req_reg         <= win_valid & ~hold_off & ~i_enter;
      level_reg       <= win_level;
      rank_reg        <= win_rank;
      vector_reg      <= win_vector;
    end
  end

  // The request drops on entry, since the core then owns the call.
  assign o_irq_req     = req_reg;
  assign o_irq_vector  = vector_reg;
  assign o_irq_level   = level_reg;
  assign o_irq_rank    = rank_reg;
  assign o_active_low  = active_low_reg;
  assign o_active_high = active_high_reg;

endmodule : tlic_ctrl

// *** testbench/tlic_ctrl_chk.sv ***
// Port checker for the two-level interrupt controller.
// Assumes it is bound to tlic_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module tlic_ctrl_chk #(
  parameter int NUM_SOURCES = 22
) (
  input wire logic                   i_clock,
  input wire logic                   i_sys_rst,
  input wire logic [7:0]             i_sfr_addr,
  input wire logic                   i_sfr_wr,
  input wire logic [7:0]             i_sfr_wdata,
  input wire logic [7:0]             o_sfr_rdata,
  input wire logic [NUM_SOURCES-1:0] i_pending,
  input wire logic                   i_enter,
  input wire logic                   i_reti_done,
  input wire logic                   o_irq_req,
  input wire logic [15:0]            o_irq_vector,
  input wire logic                   o_irq_level,
  input wire logic [4:0]             o_irq_rank,
  input wire logic                   o_active_low,
  input wire logic                   o_active_high,
  input wire logic                   o_spare_sw_flag
);
  logic [NUM_SOURCES-1:0] pend_q;
  // A request is the result of the flags seen at the same edge, so keep them.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) pend_q <= '0;
    else pend_q <= i_pending;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_vector_by_rank: assert property (
    o_irq_req |-> o_irq_vector == 16'h0003 + {o_irq_rank, 3'h0})
    else $error("vector does not match rank");
  a_unused_read_ones: assert property (i_sfr_addr == 8'hb8 |-> o_sfr_rdata[7:6] == 2'h3)
    else $error("unused level bits not ones");
  a_high_no_preempt: assert property (o_active_high |-> !o_irq_req)
    else $error("request during high routine");
  a_low_only_high: assert property (o_active_low && o_irq_req |-> o_irq_level)
    else $error("low request during low routine");
  a_enter_clears: assert property (i_enter |=> !o_irq_req)
    else $error("request stands after entry");
  a_reti_holdoff: assert property (i_reti_done |=> !o_irq_req)
    else $error("request right after return");
  a_req_has_pending: assert property (o_irq_req |-> pend_q[o_irq_rank])
    else $error("request without pending flag");
  a_spare_stored: assert property (i_sfr_wr && i_sfr_addr == 8'ha8 |=>
    o_spare_sw_flag == $past(i_sfr_wdata[6]))
    else $error("spare flag not stored");
  c_preempt: cover property (o_active_low && o_irq_req);
  c_nested: cover property (o_active_low && o_active_high);
  c_refire: cover property (i_reti_done ##1 !o_irq_req ##[1:20] o_irq_req);
endmodule : tlic_ctrl_chk
bind tlic_ctrl tlic_ctrl_chk #(.NUM_SOURCES(NUM_SOURCES)) u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
  .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_pending(i_pending),
  .i_enter(i_enter), .i_reti_done(i_reti_done), .o_irq_req(o_irq_req),
  .o_irq_vector(o_irq_vector), .o_irq_level(o_irq_level), .o_irq_rank(o_irq_rank),
  .o_active_low(o_active_low), .o_active_high(o_active_high),
  .o_spare_sw_flag(o_spare_sw_flag));

// *** testbench/tlic_core_model.sv ***
// Model of the core: long call into a routine, return, instruction stream.
// Assumes the bench steers it with hold, slow and return commands.
`timescale 1ns/100ps
module tlic_core_model (
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic i_req,
  input  wire logic i_hold,
  input  wire logic i_slow,
  input  wire logic i_ret,
  output logic      o_enter,
  output logic      o_reti,
  output logic      o_instr
);
  logic [3:0] call_reg;
  logic [3:0] busy_reg;
  wire        calling = i_req && !i_hold && !o_enter;
  // Entry after four clocks of call; a divide after a return stalls the stream.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      call_reg <= 4'h0;
      busy_reg <= 4'h0;
      o_enter  <= 1'b0;
      o_reti   <= 1'b0;
      o_instr  <= 1'b0;
    end else begin
      call_reg <= calling ? call_reg + 4'h1 : 4'h0;
      o_enter  <= calling && call_reg == 4'h3;
      o_reti   <= i_ret;
      o_instr  <= busy_reg == 4'h1 || (busy_reg == 4'h0 && !o_reti);
      if (o_reti) busy_reg <= i_slow ? 4'h8 : 4'h1;
      else if (busy_reg != 4'h0) busy_reg <= busy_reg - 4'h1;
    end
  end
endmodule : tlic_core_model

// *** testbench/tlic_ctrl_bench.sv ***
// Self-checking bench for the interrupt controller beside a core model.
// Assumes the checker binds itself to the design from its own file.
`timescale 1ns/100ps
module tlic_ctrl_bench;
  logic        i_clock = 1'b0, i_sys_rst = 1'b1;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic        wr_en = 1'b0, hit, req, lvl, act_lo, act_hi, spare;
  logic        hold = 1'b1, slow = 1'b0, ret_cmd = 1'b0, enter, reti, instr;
  logic [21:0] pend = '0, ext_en = '0, ext_lv = '0;
  logic [15:0] vec;
  logic [4:0]  rank;
  int          miscompares = 0, n_checks = 0, n;
  // Free-running 25 MHz clock.
  initial forever #20 i_clock = ~i_clock;
  tlic_ctrl u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sfr_addr(addr),
    .i_sfr_wr(wr_en), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .i_pending(pend), .i_ext_enable(ext_en), .i_ext_level(ext_lv), .i_instr_done(instr),
    .i_enter(enter), .i_reti_done(reti), .o_irq_req(req), .o_irq_vector(vec),
    .o_irq_level(lvl), .o_irq_rank(rank), .o_active_low(act_lo), .o_active_high(act_hi),
    .o_spare_sw_flag(spare));
  tlic_core_model u_core (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_req(req),
    .i_hold(hold), .i_slow(slow), .i_ret(ret_cmd), .o_enter(enter), .o_reti(reti),
    .o_instr(instr));
  // Inputs always move one nanosecond after the rising edge.
  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask : tick
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_irq(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t irq got %h exp %h", $time, got, exp);
    end
  endtask : chk_irq
  // A write strobe is dropped for a clock so two writes never meet in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    tick();
    wr_en = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    tick();
    chk_reg(rdata, exp);
  endtask : rd
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // Hang guard: the sequence needs well under two thousand clocks.
  initial begin
    #80000;
    miscompares++;
    close_out();
  end
  // Register, masking, ranking and service sequences in turn.
  initial begin
    repeat (8) @(posedge i_clock);
    #1 i_sys_rst = 1'b0;
    rd(8'ha8, 8'h00);
    chk_reg({7'h0, hit}, 8'h01);
    rd(8'hb8, 8'hc0);
    rd(8'he6, 8'h00);
    rd(8'h00, 8'h00);
    chk_reg({7'h0, hit}, 8'h00);
    wr(8'hb8, 8'h3f);
    rd(8'hb8, 8'hff);
    wr(8'hb8, 8'h00);
    rd(8'hb8, 8'hc0);
    wr(8'he6, 8'ha5);
    rd(8'he6, 8'ha5);
    $display("registers done");
    pend = 22'h1;
    wr(8'ha8, 8'h7f);
    chk_irq({14'h0, spare, req}, 16'h2);
    wr(8'ha8, 8'hbf);
    chk_irq(vec, 16'h0003);
    pend = 22'h0;
    tick();
    pend = 22'h2;
    tick();
    chk_irq({15'h0, req}, 16'h1);
    ext_en = '1;
    wr(8'he6, 8'hff);
    for (int k = 0; k < 22; k++) begin
      pend = 22'h3fffff << k;
      tick();
      chk_irq(vec, 16'h0003 + 16'(8 * k));
    end
    // Every flag pending again, so the lowest enabled main source must win.
    pend = 22'h3fffff;
    for (int j = 0; j < 6; j++) begin
      wr(8'ha8, 8'h80 | 8'(1 << j));
      chk_irq({11'h0, rank}, 16'(j));
    end
    wr(8'ha8, 8'hbf);
    for (int j = 0; j < 6; j++) begin
      wr(8'hb8, 8'(1 << j));
      chk_irq({10'h0, lvl, rank}, {10'h0, 1'b1, 5'(j)});
    end
    ext_lv = 22'h200000;
    wr(8'hb8, 8'h00);
    chk_irq({10'h0, lvl, rank}, 16'h35);
    $display("masking and ranking done");
    ext_lv = '0;
    pend = 22'h2;
    wr(8'hb8, 8'h20);
    hold = 1'b0;
    repeat (6) tick();
    chk_irq({13'h0, act_hi, act_lo, req}, 16'h2);
    pend = 22'h22;
    tick();
    chk_irq({10'h0, lvl, rank}, 16'h25);
    repeat (6) tick();
    chk_irq({13'h0, act_hi, act_lo, req}, 16'h6);
    slow = 1'b1;
    ret_cmd = 1'b1;
    tick();
    ret_cmd = 1'b0;
    n = 0;
    while (req !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk_irq(16'(n), 16'(2 + tlic_pkg::DIV_CLOCKS));
    chk_irq({11'h0, rank}, 16'h5);
    $display("service done");
    i_sys_rst = 1'b1;
    tick();
    i_sys_rst = 1'b0;
    rd(8'hb8, 8'hc0);
    close_out();
  end
endmodule : tlic_ctrl_bench
